/* divchain_top.sv */
`timescale 1ns/100ps
// What this block does
// [RULE_01] reference clock divided by reference divider gives comparison-rate pulses
// [RULE_02] alignment mode off: feedback divides oscillator by feedback divider only
// [RULE_03] alignment mode on: feedback divides by feedback, prescaler, first output divider
// [RULE_04] each of five outputs divides oscillator by prescaler times own divider
// [RULE_05] on sync, each output start delayed by its count of prescaler cycles
// [RULE_06] status pin high when any masked-in flag asserts; the code drives it low instead when status_invert is set
// [RULE_07] power control resets to zero, all blocks enabled
// [RULE_08] status is OR of flags AND mask, XOR invert setting
// [RULE_09] alignment mode selects which divided signal returns to phase detector
module clock_divider_chain_sync_delay
   import divchain_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ref_in,
   input wire logic osc_in,
   input wire logic sync_in,
   input wire logic [ref_div_w-1:0] ref_div,
   input wire logic [fb_div_w-1:0] fb_div,
   input wire logic [pre_div_w-1:0] pre_div,
   input wire logic [num_outputs*out_div_w-1:0] output_divider,
   input wire logic [num_outputs*delay_w-1:0] output_start_delay,
   input wire logic ref_align_mode,
   input wire logic [power_w-1:0] power_ctrl,
   input wire logic power_write,
   input wire logic [flag_w-1:0] status_flags,
   input wire logic [flag_w-1:0] status_mask,
   input wire logic status_invert,
   output logic pfd_ref_pulse,
   output logic pfd_fb_pulse,
   output logic [num_outputs-1:0] clk_out,
   output logic [num_outputs-1:0] out_running,
   output logic [power_w-1:0] power_state,
   output logic status_pin
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage read only by the second
   logic [2:0] meta_r;
   logic [2:0] pin_r;
   logic ref_d_r;
   logic osc_d_r;
   logic sync_d_r;
   logic ref_edge;
   logic osc_edge;
   logic sync_edge;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         meta_r <= '0;
         pin_r <= '0;
         ref_d_r <= 1'b0;
         osc_d_r <= 1'b0;
         sync_d_r <= 1'b0;
      end
      else
      begin
         meta_r <= {sync_in, osc_in, ref_in};
         pin_r <= meta_r;
         ref_d_r <= pin_r[0];
         osc_d_r <= pin_r[1];
         sync_d_r <= pin_r[2];
      end
   end

   assign ref_edge = pin_r[0] & ~ref_d_r;
   assign osc_edge = pin_r[1] & ~osc_d_r;
   assign sync_edge = pin_r[2] & ~sync_d_r;

   ////////////////////////////////////////////////////////////////////
   // power control; zero keeps everything on
   logic [power_w-1:0] pwr_r;
   logic [power_w-1:0] pwr_nxt;
   logic pll_on;
   logic out_on;

   always_comb
   begin
      pwr_nxt = power_write ? power_ctrl : pwr_r;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         pwr_r <= power_reset; // RULE_07
      else
         pwr_r <= pwr_nxt;
   end

   assign pll_on = ~(pwr_r[pwr_all] | pwr_r[pwr_pll] | pwr_r[pwr_osc]);
   assign out_on = ~(pwr_r[pwr_all] | pwr_r[pwr_out] | pwr_r[pwr_osc]);

   ////////////////////////////////////////////////////////////////////
   // reference, prescaler and feedback counters
   logic [ref_div_w-1:0] rcnt_r;
   logic [ref_div_w-1:0] rcnt_nxt;
   logic rpulse_r;
   logic rpulse_nxt;
   logic [pre_div_w-1:0] pcnt_r;
   logic [pre_div_w-1:0] pcnt_nxt;
   logic ptick_r;
   logic ptick_nxt;
   logic [fb_div_w-1:0] ncnt_r;
   logic [fb_div_w-1:0] ncnt_nxt;
   logic npulse_r;
   logic npulse_nxt;
   logic fb_src;
   logic [num_outputs-1:0] div_pulse;

   // in alignment mode the chain through output 0 feeds the N counter
   assign fb_src = ref_align_mode ? div_pulse[0] : osc_edge; // RULE_09 RULE_02 RULE_03

   always_comb
   begin
      rcnt_nxt = rcnt_r;
      rpulse_nxt = 1'b0;
      pcnt_nxt = pcnt_r;
      ptick_nxt = 1'b0;
      ncnt_nxt = ncnt_r;
      npulse_nxt = 1'b0;
      if (!pll_on)
      begin
         rcnt_nxt = '0;
         ncnt_nxt = '0;
      end
      else
      begin
         if (ref_edge)
         begin
            if (rcnt_r + 6'h01 >= ref_div) // RULE_01
            begin
               rcnt_nxt = '0;
               rpulse_nxt = 1'b1;
            end
            else
               rcnt_nxt = rcnt_r + 6'h01;
         end
         if (fb_src)
         begin
            if (ncnt_r + 10'h001 >= fb_div) // RULE_02 RULE_03
            begin
               ncnt_nxt = '0;
               npulse_nxt = 1'b1;
            end
            else
               ncnt_nxt = ncnt_r + 10'h001;
         end
      end
      if (osc_edge && out_on)
      begin
         if (pcnt_r + 3'h1 >= pre_div) // RULE_04
         begin
            pcnt_nxt = '0;
            ptick_nxt = 1'b1;
         end
         else
            pcnt_nxt = pcnt_r + 3'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rcnt_r <= '0;
         rpulse_r <= 1'b0;
         pcnt_r <= '0;
         ptick_r <= 1'b0;
         ncnt_r <= '0;
         npulse_r <= 1'b0;
      end
      else
      begin
         rcnt_r <= rcnt_nxt;
         rpulse_r <= rpulse_nxt;
         pcnt_r <= pcnt_nxt;
         ptick_r <= ptick_nxt;
         ncnt_r <= ncnt_nxt;
         npulse_r <= npulse_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sync sequencer and per-output start delay
   sync_state_t st_r;
   sync_state_t st_nxt;
   logic [num_outputs*delay_w-1:0] dly_r;
   logic [num_outputs*delay_w-1:0] dly_nxt;
   logic [num_outputs-1:0] run_r;
   logic [num_outputs-1:0] run_nxt;

   always_comb
   begin
      st_nxt = st_r;
      dly_nxt = dly_r;
      run_nxt = run_r;
      case (st_r)
         sync_idle:
         begin
            run_nxt = '1;
            if (sync_edge)
               st_nxt = sync_hold;
         end
         sync_hold:
         begin
            // outputs stop and delays reload before counting
            run_nxt = '0;
            dly_nxt = output_start_delay;
            st_nxt = sync_count;
         end
         sync_count:
         begin
            for (int i = 0; i < num_outputs; i++)
            begin
               if (dly_r[i*delay_w +: delay_w] == 8'h00)
                  run_nxt[i] = 1'b1;
               else if (ptick_r)
                  dly_nxt[i*delay_w +: delay_w] = dly_r[i*delay_w +: delay_w] - 8'h01; // RULE_05
            end
            if (&run_r)
               st_nxt = sync_run;
         end
         default:
         begin
            run_nxt = '1;
            st_nxt = sync_idle;
         end
      endcase
      if (!out_on)
         run_nxt = '0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_r <= sync_idle;
         dly_r <= '0;
         run_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         dly_r <= dly_nxt;
         run_r <= run_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output dividers
   logic [num_outputs-1:0] div_clk;

   for (genvar g = 0; g < num_outputs; g++)
   begin : g_out
      divchain_if ch ();
      assign ch.tick = ptick_r;
      assign ch.ratio = output_divider[g*out_div_w +: out_div_w];
      assign ch.load = (st_r == sync_hold);
      assign ch.enable = run_r[g]; // RULE_05
      assign div_pulse[g] = ch.pulse;
      assign div_clk[g] = ch.clk_out;
      divchain_counter u_div (
         .clk(clk),
         .rst_b(rst_b),
         .dv(ch.divider)
      );
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   logic stat_nxt;

   always_comb
   begin
      stat_nxt = (|(status_flags & status_mask)) ^ status_invert; // RULE_06 RULE_08
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pfd_ref_pulse <= 1'b0;
         pfd_fb_pulse <= 1'b0;
         clk_out <= '0;
         out_running <= '0;
         power_state <= power_reset;
         status_pin <= 1'b0;
      end
      else
      begin
         pfd_ref_pulse <= rpulse_r;
         pfd_fb_pulse <= npulse_r;
         clk_out <= div_clk;
         out_running <= run_r;
         power_state <= pwr_r;
         status_pin <= stat_nxt;
      end
   end
endmodule

/* divchain_pkg.sv */
package divchain_pkg;
   localparam int ref_div_w = 6;
   localparam int fb_div_w = 10;
   localparam int pre_div_w = 3;
   localparam int out_div_w = 4;
   localparam int delay_w = 8;
   localparam int num_outputs = 5;
   localparam int flag_w = 7;
   localparam int power_w = 5;
   localparam logic [power_w-1:0] power_reset = 5'h00;
   localparam logic [flag_w-1:0] mask_reset = 7'h0a;
   localparam logic invert_reset = 1'b1;
   localparam int flag_ref_valid = 0;
   localparam int flag_lock = 1;
   localparam int flag_amp_low = 4;
   localparam int flag_amp_high = 5;
   localparam int pwr_all = 0;
   localparam int pwr_pll = 1;
   localparam int pwr_out = 2;
   localparam int pwr_osc = 3;
   localparam int pwr_refdet = 4;
   typedef enum logic [1:0] {
      sync_idle = 2'b00,
      sync_hold = 2'b01,
      sync_count = 2'b11,
      sync_run = 2'b10
   } sync_state_t;
endpackage

/* divchain_if.sv */
`timescale 1ns/100ps
interface divchain_if;
   logic tick;
   logic [divchain_pkg::out_div_w-1:0] ratio;
   logic load;
   logic enable;
   logic pulse;
   logic clk_out;
   modport chain (output tick, output ratio, output load, output enable,
      input pulse, input clk_out);
   modport divider (input tick, input ratio, input load, input enable,
      output pulse, output clk_out);
endinterface

/* divchain_counter.sv */
`timescale 1ns/100ps
module divchain_counter
   import divchain_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   divchain_if.divider dv
);
   logic [out_div_w-1:0] cnt_r;
   logic [out_div_w-1:0] cnt_nxt;
   logic half_r;
   logic half_nxt;
   logic pulse_r;
   logic pulse_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      half_nxt = half_r;
      pulse_nxt = 1'b0;
      if (dv.load || !dv.enable)
      begin
         cnt_nxt = '0;
         half_nxt = 1'b0;
      end
      else if (dv.tick)
      begin
         // ratio 0 treated as 1 so the divider never stalls
         if (cnt_r + 4'h1 >= dv.ratio)
         begin
            cnt_nxt = '0;
            pulse_nxt = 1'b1;
         end
         else
         begin
            cnt_nxt = cnt_r + 4'h1;
         end
         half_nxt = ((cnt_nxt) < (dv.ratio >> 1)) ? 1'b1 : 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         cnt_r <= '0;
         half_r <= 1'b0;
         pulse_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         half_r <= half_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign dv.pulse = pulse_r;
   assign dv.clk_out = half_r;
endmodule

/* divchain_properties.sv */
`timescale 1ns/100ps
module divchain_properties
   import divchain_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [power_w-1:0] power_ctrl,
   input wire logic power_write,
   input wire logic [flag_w-1:0] status_flags,
   input wire logic [flag_w-1:0] status_mask,
   input wire logic status_invert,
   input wire logic pfd_ref_pulse,
   input wire logic pfd_fb_pulse,
   input wire logic [num_outputs-1:0] out_running,
   input wire logic [power_w-1:0] power_state,
   input wire logic status_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////
   // past of rst_b guards the first edge, where inputs were not yet evaluated
   property p_stat;
      $past(rst_b) |-> status_pin ==
         ((|($past(status_flags) & $past(status_mask))) ^ $past(status_invert));
   endproperty
   a_stat: assert property (p_stat) else $error("status pin equation");
   property p_hi;
      (|(status_flags & status_mask)) && !status_invert |=> status_pin;
   endproperty
   a_hi: assert property (p_hi) else $error("status pin not high");
   property p_lo;
      !(|(status_flags & status_mask)) && !status_invert |=> !status_pin;
   endproperty
   a_lo: assert property (p_lo) else $error("status pin not low");
   property p_pwr;
      power_write |=> ##1 power_state == $past(power_ctrl, 2);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power word not loaded");
   property p_pwr_rst;
      $rose(rst_b) |-> power_state == 5'h00;
   endproperty
   a_pwr_rst: assert property (p_pwr_rst) else $error("power word reset");
   property p_ref1;
      pfd_ref_pulse |=> !pfd_ref_pulse;
   endproperty
   a_ref1: assert property (p_ref1) else $error("ref pulse too long");
   property p_fb1;
      pfd_fb_pulse |=> !pfd_fb_pulse;
   endproperty
   a_fb1: assert property (p_fb1) else $error("fb pulse too long");
   property p_pll;
      power_state[pwr_pll] [*4] |-> !pfd_ref_pulse && !pfd_fb_pulse;
   endproperty
   a_pll: assert property (p_pll) else $error("pfd pulse while pll down");
   property p_out;
      power_state[pwr_out] [*4] |-> out_running == 5'h00;
   endproperty
   a_out: assert property (p_out) else $error("output runs while down");
endmodule

/* clock_divider_chain_sync_delay_bench.sv */
`timescale 1ns/100ps
module clock_divider_chain_sync_delay_bench
   import divchain_pkg::*;
;
   logic clk = 0, rst_b = 0, ref_in = 0, osc_in = 0, sync_in = 0, ref_align_mode = 0;
   logic power_write = 0, status_invert = 0;
   logic [ref_div_w-1:0] ref_div = '0;
   logic [fb_div_w-1:0] fb_div = '0;
   logic [pre_div_w-1:0] pre_div = '0;
   logic [num_outputs*out_div_w-1:0] output_divider = '0;
   logic [num_outputs*delay_w-1:0] output_start_delay = '0;
   logic [power_w-1:0] power_ctrl = '0, power_state;
   logic [flag_w-1:0] status_flags = '0, status_mask = '0;
   logic pfd_ref_pulse, pfd_fb_pulse, status_pin, iv, e;
   logic [num_outputs-1:0] clk_out, out_running, z;
   logic [1:0] ph = 0;
   logic [6:0] fl, mk;
   int num_errors = 0, tests_run = 0, cyc = 0, p, r, n, m[5], d[5], t[5];
   // model of the status pin: one expected level per programmed setting
   int exp_q[$];
   wire [6:0] mon = {pfd_fb_pulse, pfd_ref_pulse, clk_out};
   always #25 clk = ~clk;
   // pins toggle every two cycles: design needs edges slower than clk/2
   always @(posedge clk)
   begin
      ph <= ph + 2'h1;
      ref_in <= ph[1];
      osc_in <= ph[1];
      cyc <= cyc + 1;
   end
   clock_divider_chain_sync_delay dut (.clk(clk), .rst_b(rst_b), .ref_in(ref_in),
      .osc_in(osc_in), .sync_in(sync_in), .ref_div(ref_div), .fb_div(fb_div),
      .pre_div(pre_div), .output_divider(output_divider),
      .output_start_delay(output_start_delay), .ref_align_mode(ref_align_mode),
      .power_ctrl(power_ctrl), .power_write(power_write), .status_flags(status_flags),
      .status_mask(status_mask), .status_invert(status_invert),
      .pfd_ref_pulse(pfd_ref_pulse), .pfd_fb_pulse(pfd_fb_pulse), .clk_out(clk_out),
      .out_running(out_running), .power_state(power_state), .status_pin(status_pin));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (x !== g)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", s, x, g);
      end
   endtask
   // skips the first rise: it may come from the old setting
   task automatic period(input int i, input int x, input string s);
      int k, t0;
      logic pb, b;
      k = 0;
      t0 = 0;
      pb = 1'b1;
      repeat (12000)
      begin
         @(posedge clk);
         #1;
         b = mon[i];
         if (b === 1'b1 && pb === 1'b0)
         begin
            k++;
            if (k == 2) t0 = cyc;
            if (k == 3) break;
         end
         pb = b;
      end
      chk(s, x, cyc - t0);
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(50 * 60000);
      num_errors++;
      conclude;
   end
   initial
   begin
      void'($urandom(31057));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      chk("power_state", 5'h00, power_state);
      repeat (30)
      begin
         @(posedge clk);
         fl = 7'($urandom);
         mk = 7'($urandom);
         iv = 1'($urandom);
         exp_q.push_back((|(fl & mk)) ^ iv);
         status_flags <= fl;
         status_mask <= mk;
         status_invert <= iv;
         power_ctrl <= 5'($urandom);
         power_write <= 1'b1;
         @(posedge clk);
         power_write <= 1'b0;
         @(posedge clk);
         #1;
         e = 1'(exp_q.pop_front());
         chk("status_pin", e, status_pin);
         chk("power_state", power_ctrl, power_state);
      end
      @(posedge clk);
      power_ctrl <= 5'h00;
      power_write <= 1'b1;
      @(posedge clk);
      power_write <= 1'b0;
      p = 1 + $urandom % 7;
      r = $urandom % 8;
      n = 1 + $urandom % 6;
      pre_div <= 3'(p);
      ref_div <= 6'(r);
      fb_div <= 10'(n);
      for (int i = 0; i < 5; i++)
      begin
         m[i] = 2 + $urandom % 14;
         d[i] = 1 + $urandom % 8;
         output_divider[4*i+:4] <= 4'(m[i]);
         output_start_delay[8*i+:8] <= 8'(d[i]);
         t[i] = 0;
      end
      z = '0;
      repeat (8) @(posedge clk);
      sync_in <= 1'b1;
      repeat (4) @(posedge clk);
      sync_in <= 1'b0;
      repeat (600)
      begin
         @(posedge clk);
         #1;
         for (int i = 0; i < 5; i++)
            if (out_running[i] === 1'b0) z[i] = 1'b1;
            else if (z[i] && t[i] == 0) t[i] = cyc;
      end
      // differences only: the absolute start depends on the sync pipeline
      for (int i = 0; i < 5; i++)
         chk("start delay", 4 * p * (d[i] - d[1]), t[i] - t[1]);
      for (int i = 0; i < 5; i++)
         period(i, 4 * p * m[i], "output period");
      period(5, 4 * (r == 0 ? 1 : r), "ref period");
      period(6, 4 * n, "fb period");
      @(posedge clk);
      ref_align_mode <= 1'b1;
      period(6, 4 * n * p * m[0], "fb period aligned");
      @(posedge clk);
      power_ctrl <= 5'h06;
      power_write <= 1'b1;
      @(posedge clk);
      power_write <= 1'b0;
      repeat (12) @(posedge clk);
      #1;
      chk("out_running", 5'h00, out_running);
      conclude;
   end
endmodule
bind clock_divider_chain_sync_delay divchain_properties chk (.clk(clk), .rst_b(rst_b),
   .power_ctrl(power_ctrl), .power_write(power_write), .status_flags(status_flags),
   .status_mask(status_mask), .status_invert(status_invert),
   .pfd_ref_pulse(pfd_ref_pulse), .pfd_fb_pulse(pfd_fb_pulse),
   .out_running(out_running), .power_state(power_state), .status_pin(status_pin));
